//--- acs_pkg.sv
// constants, field layout and state type shared by the conversion sequencer
package acs_pkg;

   // clock and time base
   localparam int ACS_CLK_NS   = 50;                        // mclk period, 20 MHz
   localparam int ACS_TICK_NS  = 1000;                      // sequencing time unit, 1 us
   localparam int ACS_TICK_CYC = ACS_TICK_NS / ACS_CLK_NS;  // mclk cycles per tick

   // widths
   localparam int ACS_AW = 8;                               // register address width
   localparam int ACS_DW = 32;                              // register data width
   localparam int ACS_CW = 23;                              // tick counter width

   // register byte offsets
   localparam logic [7:0] ACS_OFF_MODE_REGISTER_0  = 8'h00;           // mode_register_0
   localparam logic [7:0] ACS_OFF_DELAY  = 8'h04;           // start delay in us
   localparam logic [7:0] ACS_OFF_STATUS = 8'h08;           // sticky events, write one to clear
   localparam logic [7:0] ACS_OFF_MASK   = 8'h0C;           // interrupt enables
   localparam logic [7:0] ACS_OFF_STATE  = 8'h10;           // live sequencer state

   // mode_register_0 layout
   localparam int ACS_FLT_LSB   = 0;                        // filter type, 3 bits
   localparam int ACS_FLT_W     = 3;
   localparam int ACS_CONV_BIT  = 4;                        // conversion_mode_bit, 1 = single
   localparam int ACS_CHOP_BIT  = 5;                        // chop mode
   localparam int ACS_ACX_BIT   = 6;                        // ac-excitation mode
   localparam int ACS_CRC_BIT   = 7;                        // crc checking on frames
   localparam int ACS_DR_LSB    = 8;                        // data_rate_field, 5 bits
   localparam int ACS_DR_W      = 5;
   localparam int ACS_MODE_REGISTER_0_W   = 13;                       // implemented bits
   localparam logic [12:0] ACS_MODE_REGISTER_0_RST = 13'h0000;       // mode_register_0 after reset

   // filter codes: 0..4 are sinc1..sinc5, 5 and up are fir
   localparam logic [2:0] ACS_FLT_SINC1 = 3'h0;
   localparam logic [2:0] ACS_FLT_FIR   = 3'h5;

   // timing in us
   localparam int ACS_START_DELAY_US = 50;                  // default start-conversion delay
   localparam logic [ACS_CW-1:0] ACS_DELAY_RST = 23'(ACS_START_DELAY_US);
   localparam logic [ACS_CW-1:0] ACS_OVH_US    = 23'h00015E; // data processing overhead

   // status bits
   localparam int ACS_ST_W      = 3;
   localparam int ACS_ST_RESULT = 0;                        // result became ready
   localparam int ACS_ST_START  = 1;                        // start accepted
   localparam int ACS_ST_STOP   = 2;                        // stop accepted

   // serial commands and frame lengths
   localparam logic [7:0] ACS_CMD_START = 8'h08;            // opcode, arbitrary
   localparam logic [7:0] ACS_CMD_STOP  = 8'h0A;            // opcode, arbitrary
   localparam logic [5:0] ACS_FRAME_PLAIN = 6'h10;          // falling edges, crc off
   localparam logic [5:0] ACS_FRAME_CRC   = 6'h20;          // falling edges, crc on
   localparam logic [5:0] ACS_OP_BITS     = 6'h08;          // opcode is the first byte

   // output data period in us per data_rate_field code
   localparam int ACS_DR_CODES = 17;
   localparam logic [ACS_CW-1:0] ACS_PERIOD_US [0:ACS_DR_CODES-1] = '{
      23'h061A80, 23'h030D40, 23'h0186A0, 23'h00EB51, 23'h00C350, 23'h004E20,
      23'h00411B, 23'h002710, 23'h0009C4, 23'h000341, 23'h0001A1, 23'h0000D0,
      23'h00008B, 23'h000045, 23'h000034, 23'h000027, 23'h000019};

   // sequencer states, gray along idle -> delay -> convert
   typedef enum logic [1:0] {
      ACS_IDLE = 2'h0,
      ACS_DLY  = 2'h1,
      ACS_CONV = 2'h3
   } acs_state_t;

endpackage

//--- acs_tick.sv
// microsecond tick divider, restartable so a trigger aligns the time base
module acs_tick #(
   parameter int TICK_CYC = acs_pkg::ACS_TICK_CYC
) (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic clr,
   output logic      tick
);
   import acs_pkg::*;

   logic [15:0] div_q;   // cycles since last tick

   // count mclk cycles, pulse once per tick period
   always_ff @(posedge mclk) begin
      if (sys_rst || clr) begin
         div_q <= 16'h0000;
         tick  <= 1'b0;
      end else if (div_q == 16'(TICK_CYC - 1)) begin
         div_q <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         div_q <= div_q + 16'h0001;
         tick  <= 1'b0;
      end
   end

endmodule

//--- acs_cmd_rx.sv
// serial command receiver: samples the link pins on mclk and decodes start and stop
module acs_cmd_rx (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic sdi,
   input  wire logic crc_en,
   output logic      start_cmd,
   output logic      stop_cmd
);
   import acs_pkg::*;

   logic [2:0] s1_q;      // first stage, read only by s2_q
   logic [2:0] s2_q;      // synchronised sclk, cs_n, sdi
   logic       sclk3_q;   // delayed sclk for edge finding
   logic [5:0] edges_q;   // falling edges in this frame
   logic [7:0] shift_q;   // opcode shifter
   logic       fall;      // falling sclk edge seen
   logic [5:0] edges_d;   // edge count after this edge

   // two flops on every link pin
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               s1_q[gi] <= 1'b1;
               s2_q[gi] <= 1'b1;
            end else begin
               s1_q[gi] <= (gi == 0) ? sclk : (gi == 1) ? cs_n : sdi;
               s2_q[gi] <= s1_q[gi];
            end
         end
      end
   endgenerate

   assign fall    = sclk3_q & ~s2_q[0];
   assign edges_d = edges_q + 6'h01;

   // count edges, capture opcode, act on the closing edge of the frame
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sclk3_q   <= 1'b1;
         edges_q   <= 6'h00;
         shift_q   <= 8'h00;
         start_cmd <= 1'b0;
         stop_cmd  <= 1'b0;
      end else begin
         sclk3_q   <= s2_q[0];
         start_cmd <= 1'b0;
         stop_cmd  <= 1'b0;
         if (s2_q[1]) begin
            // deselected: frame aborts, a partial frame does nothing
            edges_q <= 6'h00;
         end else if (fall) begin
            edges_q <= edges_d;
            if (edges_d <= ACS_OP_BITS) begin
               shift_q <= {shift_q[6:0], s2_q[2]};
            end
            // command takes effect on edge 16, or 32 with crc on [R2]
            if (edges_d == (crc_en ? ACS_FRAME_CRC : ACS_FRAME_PLAIN)) begin
               start_cmd <= (shift_q == ACS_CMD_START);
               stop_cmd  <= (shift_q == ACS_CMD_STOP);
            end
         end
      end
   end

endmodule

//--- acs_sequencer.sv
// conversion sequencer top: start pin, commands, modes, latency and result ready
//
// Operation
// R1 - host keeps start pin low using commands
// R2 - commands act on 16th or 32nd falling edge
// R3 - bit 4 of mode register selects single
// R4 - continuous: start begins endless conversions
// R5 - ready high at initiation, low at result
// R6 - continuous stop: finish current, then halt
// R7 - new start abandons conversion, restarts fresh
// R8 - single: one conversion per start, then halt
// R9 - single: stop does not abort conversion
// R10 - fir and sinc1 settle in one cycle
// R11 - first latency includes delay and overhead
// R12 - continuous: later results one data period apart
// R13 - chop/acx: first doubled, then normal latency
// R14 - data rate and filter from mode register
// R15 - programmable start delay, default 50 us
// R16 - start/stop commands act like pin edges
//
// Local design decisions: the register addresses and strobed register access.
module acs_sequencer #(
   parameter int TICK_CYC = acs_pkg::ACS_TICK_CYC
) (
   input  wire logic                       mclk,
   input  wire logic                       sys_rst,
   input  wire logic                       start_pin,
   input  wire logic                       sclk,
   input  wire logic                       cs_n,
   input  wire logic                       sdi,
   input  wire logic [acs_pkg::ACS_AW-1:0] reg_addr,
   input  wire logic [acs_pkg::ACS_DW-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [acs_pkg::ACS_DW-1:0] reg_rdata,
   output logic                            result_ready_n,
   output logic                            result_strobe,
   output logic                            irq
);
   import acs_pkg::*;

   // registers
   logic [ACS_MODE_REGISTER_0_W-1:0] mode_register_0_q;    // mode_register_0
   logic [ACS_CW-1:0]      delay_q;    // start delay in us
   logic [ACS_ST_W-1:0]    status_q;   // sticky events
   logic [ACS_ST_W-1:0]    mask_q;     // interrupt enables

   // sequencer state
   acs_state_t             state_q;    // idle, delay or convert
   logic [ACS_CW-1:0]      cnt_q;      // ticks left in this phase
   logic                   run_q;      // continuous stream wanted
   logic                   first_q;    // next conversion is the first
   logic                   pin1_q;     // start pin first stage
   logic                   pin2_q;     // start pin synchronised
   logic                   pin3_q;     // start pin delayed

   // decoded controls
   logic                   single;     // single-shot operation
   logic                   chop;       // chop or ac-excitation
   logic                   crc_en;     // frames carry crc
   logic [ACS_FLT_W-1:0]   flt;        // filter type
   logic [ACS_DR_W-1:0]    dr;         // data rate code
   logic [ACS_CW-1:0]      period;     // one output data period
   logic [2:0]             settle;     // periods to settle
   logic [ACS_CW-1:0]      base;       // settle time plus overhead
   logic [ACS_CW-1:0]      lat;        // normal latency with delay
   logic                   start_cmd;  // start command accepted
   logic                   stop_cmd;   // stop command accepted
   logic                   trig;       // start event
   logic                   stop_ev;    // stop event
   logic                   tick;       // 1 us time base
   logic                   phase_end;  // current phase has run out
   logic                   res_done;   // conversion result ready now
   logic                   go_on;      // another conversion follows
   logic                   wr_status;  // write to status register
   logic [ACS_ST_W-1:0]    ev_set;     // events this cycle

   // mode_register_0 fields [R3] [R14]
   assign single = mode_register_0_q[ACS_CONV_BIT];
   assign chop   = mode_register_0_q[ACS_CHOP_BIT] | mode_register_0_q[ACS_ACX_BIT];
   assign crc_en = mode_register_0_q[ACS_CRC_BIT];
   assign flt    = mode_register_0_q[ACS_FLT_LSB +: ACS_FLT_W];
   assign dr     = mode_register_0_q[ACS_DR_LSB +: ACS_DR_W];

   // unused rate codes fall back on the fastest rate [R14]
   assign period = (32'(dr) < ACS_DR_CODES) ? ACS_PERIOD_US[dr]
                                            : ACS_PERIOD_US[ACS_DR_CODES-1];

   // fir and sinc1 settle within one period, sincN needs N [R10]
   assign settle = (flt >= ACS_FLT_FIR) ? 3'h1 : flt + 3'h1;
   assign base   = ACS_CW'(settle * period) + ACS_OVH_US;  // [R11]
   assign lat    = delay_q + base;                           // [R11]

   // start pin comes from outside: two flops before use
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin1_q <= 1'b0;
         pin2_q <= 1'b0;
         pin3_q <= 1'b0;
      end else begin
         pin1_q <= start_pin;
         pin2_q <= pin1_q;
         pin3_q <= pin2_q;
      end
   end

   // serial command path
   acs_cmd_rx u_rx (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .sclk      (sclk),
      .cs_n      (cs_n),
      .sdi       (sdi),
      .crc_en    (crc_en),
      .start_cmd (start_cmd),
      .stop_cmd  (stop_cmd)
   );

   // pin and commands merge; the host keeps the pin low when commanding [R1] [R16]
   assign trig    = (pin2_q & ~pin3_q) | start_cmd;
   assign stop_ev = (~pin2_q & pin3_q) | stop_cmd;

   // time base restarts on a trigger so phases are whole ticks
   acs_tick #(
      .TICK_CYC (TICK_CYC)
   ) u_tick (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .clr     (trig),
      .tick    (tick)
   );

   assign phase_end = (cnt_q == {ACS_CW{1'b0}});
   assign res_done  = (state_q == ACS_CONV) && phase_end && !trig;
   // single shot never continues; continuous continues until stopped [R4] [R8]
   assign go_on     = !single && run_q && !stop_ev;

   // stream request: start sets, stop clears [R4] [R6]
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         run_q <= 1'b0;
      end else if (trig) begin
         run_q <= 1'b1;
      end else if (stop_ev) begin
         run_q <= 1'b0;
      end
   end

   // phase sequencing; a trigger abandons whatever runs [R7]
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= ACS_IDLE;
         cnt_q   <= {ACS_CW{1'b0}};
         first_q <= 1'b0;
      end else if (trig) begin
         // fresh start: delay first [R15]
         state_q <= ACS_DLY;
         cnt_q   <= delay_q;
         first_q <= 1'b1;
      end else begin
         unique case (state_q)
            ACS_IDLE: begin
               cnt_q <= {ACS_CW{1'b0}};
            end
            ACS_DLY: begin
               if (phase_end) begin
                  state_q <= ACS_CONV;
                  // chop doubles the first result's latency [R13]
                  cnt_q   <= (first_q && chop) ? base + lat : base;
               end else if (tick) begin
                  cnt_q <= cnt_q - 23'h000001;
               end
            end
            ACS_CONV: begin
               // stop lets the running conversion finish [R6] [R9]
               if (phase_end) begin
                  first_q <= 1'b0;
                  if (!go_on) begin
                     state_q <= ACS_IDLE;  // [R8]
                  end else if (chop) begin
                     // chop: later results one normal latency apart [R13]
                     state_q <= ACS_DLY;
                     cnt_q   <= delay_q;
                  end else begin
                     cnt_q <= period;      // [R12]
                  end
               end else if (tick) begin
                  cnt_q <= cnt_q - 23'h000001;
               end
            end
            default: begin
               state_q <= ACS_IDLE;
               cnt_q   <= {ACS_CW{1'b0}};
            end
         endcase
      end
   end

   // ready output: high at initiation, low with the result [R5]
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         result_ready_n <= 1'b0;
         result_strobe  <= 1'b0;
      end else begin
         result_strobe <= res_done;
         if (trig) begin
            result_ready_n <= 1'b1;
         end else if (res_done) begin
            result_ready_n <= 1'b0;
         end else if (state_q == ACS_CONV && cnt_q == 23'h000001 && tick) begin
            // streaming: mark the next conversion in progress one mclk cycle before its result
            result_ready_n <= 1'b1;
         end
      end
   end

   // register writes; mode changes take effect on the next phase load
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode_register_0_q <= ACS_MODE_REGISTER_0_RST;
         delay_q <= ACS_DELAY_RST;  // [R15]
         mask_q  <= {ACS_ST_W{1'b0}};
      end else if (reg_wr) begin
         if (reg_addr == ACS_OFF_MODE_REGISTER_0) begin
            mode_register_0_q <= reg_wdata[ACS_MODE_REGISTER_0_W-1:0];
         end
         if (reg_addr == ACS_OFF_DELAY) begin
            delay_q <= reg_wdata[ACS_CW-1:0];
         end
         if (reg_addr == ACS_OFF_MASK) begin
            mask_q <= reg_wdata[ACS_ST_W-1:0];
         end
      end
   end

   // sticky events; a new event beats a same-cycle clear
   assign wr_status = reg_wr && (reg_addr == ACS_OFF_STATUS);
   assign ev_set    = {stop_ev, trig, res_done};

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         status_q <= {ACS_ST_W{1'b0}};
      end else begin
         status_q <= (status_q & ~(wr_status ? reg_wdata[ACS_ST_W-1:0] : {ACS_ST_W{1'b0}}))
                     | ev_set;
      end
   end

   // level interrupt from a flop, one cycle behind the status
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end

   // read data valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= {ACS_DW{1'b0}};
      end else if (reg_rd) begin
         unique case (reg_addr)
            ACS_OFF_MODE_REGISTER_0:  reg_rdata <= ACS_DW'(mode_register_0_q);
            ACS_OFF_DELAY:  reg_rdata <= ACS_DW'(delay_q);
            ACS_OFF_STATUS: reg_rdata <= ACS_DW'(status_q);
            ACS_OFF_MASK:   reg_rdata <= ACS_DW'(mask_q);
            ACS_OFF_STATE:  reg_rdata <= ACS_DW'({first_q, run_q, state_q});
            default:        reg_rdata <= {ACS_DW{1'b0}};
         endcase
      end else begin
         reg_rdata <= {ACS_DW{1'b0}};
      end
   end

   // checks on the sequencing
   AST_TRIG_READY_HIGH: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
      trig |=> result_ready_n && state_q == ACS_DLY)
      else $error("ready not raised on start");

   AST_RESULT_READY_LOW: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
      res_done |=> !result_ready_n && result_strobe && status_q[ACS_ST_RESULT])
      else $error("ready not lowered at result");

   AST_DELAY_LOADED: assert property (@(posedge mclk) disable iff (sys_rst) // [R15]
      trig |=> cnt_q == $past(delay_q))
      else $error("start delay not loaded");

   AST_SINGLE_HALTS: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
      res_done && single |=> state_q == ACS_IDLE)
      else $error("single shot did not halt");

   AST_STOP_FINISHES: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
      stop_ev && !trig && state_q == ACS_CONV && !phase_end |=> state_q == ACS_CONV)
      else $error("stop aborted a conversion");

   AST_CONT_PERIOD: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
      res_done && go_on && !chop |=> state_q == ACS_CONV && cnt_q == $past(period))
      else $error("continuous spacing wrong");

   AST_CHOP_FIRST: assert property (@(posedge mclk) disable iff (sys_rst) // [R13]
      state_q == ACS_DLY && phase_end && !trig && first_q && chop
      |=> cnt_q == $past(base) + $past(lat))
      else $error("chop first latency not doubled");

   AST_STOP_CLEARS_RUN: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
      stop_ev && !trig |=> !run_q ##1 (state_q != ACS_CONV || !phase_end || !go_on))
      else $error("stop did not end the stream");

   AST_ONE_CYCLE_SETTLE: assert property (@(posedge mclk) disable iff (sys_rst) // [R10]
      flt == ACS_FLT_SINC1 || flt >= ACS_FLT_FIR |-> base == period + ACS_OVH_US)
      else $error("single-cycle filter latency wrong");

endmodule

//--- acs_host_model.sv
// host stand-in for the sequencer: start pin level and serial start and stop frames
module acs_host_model (
   output logic start_pin,
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle levels from time zero, link clock parked high between frames
   initial begin
      start_pin = 1'b0; // stays low whenever frames drive conversions
      sclk      = 1'b1;
      cs_n      = 1'b1;
      sdi       = 1'b1;
   end

   // pin change lands off the mclk edge, unrelated in phase
   task automatic pin(input logic v);
      #13 start_pin = v;
   endtask

   // one frame of 16 or 32 falling edges, opcode msb first, padding zero
   task automatic send(input logic [7:0] op, input int edges);
      // step off the mclk edge so no link change races the sampling flops
      #7 cs_n = 1'b0;
      for (int i = 0; i < edges; i++) begin
         sdi = (i < 8) ? op[7-i] : 1'b0;
         #200 sclk = 1'b0;
         #200 sclk = 1'b1;
      end
      cs_n = 1'b1;
      // released line must not keep showing the last bit
      sdi = ~sdi;
      #200;
   endtask
endmodule

//--- adc_conversion_sequencer_bench.sv
// self-checking bench of the conversion sequencer
module adc_conversion_sequencer_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import acs_pkg::*;

   localparam int DLY  = 10;    // shortened start delay, one tick per mclk
   localparam int PER  = 25;    // period of rate code 16
   localparam int OVH  = 350;   // processing overhead in ticks
   localparam int BASE = DLY + PER + OVH;
   localparam int CEIL = 20000; // whole run needs about 9000 cycles

   logic              mclk      = 1'b0;
   logic              sys_rst   = 1'b1;
   logic              start_pin;
   logic              sclk;
   logic              cs_n;
   logic              sdi;
   logic [ACS_AW-1:0] reg_addr  = '0;
   logic [ACS_DW-1:0] reg_wdata = '0;
   logic              reg_wr    = 1'b0;
   logic              reg_rd    = 1'b0;
   logic [ACS_DW-1:0] reg_rdata;
   logic              result_ready_n;
   logic              result_strobe;
   logic              irq;
   int                fails     = 0;
   int                checks    = 0;
   int                cyc       = 0;
   int                n;         // cycles waited for the last result

   // tick of one mclk keeps every latency short
   acs_sequencer #(.TICK_CYC(1)) dut (
      .mclk(mclk), .sys_rst(sys_rst), .start_pin(start_pin), .sclk(sclk),
      .cs_n(cs_n), .sdi(sdi), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .result_ready_n(result_ready_n), .result_strobe(result_strobe), .irq(irq)
   );

   acs_host_model host (
      .start_pin(start_pin), .sclk(sclk), .cs_n(cs_n), .sdi(sdi)
   );

   // 20 MHz
   initial begin
      forever #25 mclk = ~mclk;
   end

   // hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == CEIL) begin
         fails++;
         end_of_test();
      end
   end

   // value compare, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // cycle count compare within a tolerance for sync and frame slack
   task automatic near(input int exp, input int tol);
      checks++;
      if (n <= exp - tol || n >= exp + tol) begin
         fails++;
         $display("MISMATCH %0t waited %0d cycles expected %0d", $time, n, exp);
      end
   endtask

   // one-cycle write
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask

   // one-cycle read, data looked at only in the cycle after
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask

   // count cycles until a result strobe, bounded
   task automatic wait_res(input int mx);
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (result_strobe !== 1'b1 && n < mx);
   endtask

   // reset values, unmapped read, then shorten the delay
   task automatic t_reset;
      rd(ACS_OFF_MODE_REGISTER_0, 32'h0);
      rd(ACS_OFF_DELAY, 32'h32);
      rd(8'h40, 32'h0);
      wr(ACS_OFF_DELAY, 32'(DLY));
   endtask

   // pin driven stream, then pin low finishes one more and halts
   task automatic t_cont;
      wr(ACS_OFF_MODE_REGISTER_0, 32'h1000);
      host.pin(1'b1);
      repeat (6) @(posedge mclk);
      #1 chk(32'(result_ready_n), 32'h1);
      wait_res(2000);
      near(BASE - 2, 8);
      chk(32'(result_ready_n), 32'h0);
      repeat (2) begin
         wait_res(200);
         near(PER, 3);
      end
      host.pin(1'b0);
      wait_res(200);
      near(PER, 3);
      wait_res(600);
      chk(32'(result_strobe), 32'h0);
   endtask

   // single shot by command for sinc1, sinc3 and fir
   task automatic t_single;
      logic [2:0] f;
      int         s;
      for (int i = 0; i < 3; i++) begin
         f = (i == 0) ? ACS_FLT_SINC1 : (i == 1) ? 3'h2 : ACS_FLT_FIR;
         s = (i == 1) ? 3 : 1;
         wr(ACS_OFF_MODE_REGISTER_0, 32'h1010 | 32'(f));
         host.send(ACS_CMD_START, 16);
         wait_res(2000);
         near(DLY + s * PER + OVH, 8);
      end
      wait_res(600);
      chk(32'(result_strobe), 32'h0);
   endtask

   // second start restarts, stop leaves a single conversion running
   task automatic t_restart;
      host.send(ACS_CMD_START, 16);
      repeat (150) @(posedge mclk);
      host.send(ACS_CMD_START, 16);
      wait_res(2000);
      near(BASE, 8);
      host.send(ACS_CMD_START, 16);
      host.send(ACS_CMD_STOP, 16);
      wait_res(2000);
      near(BASE - 132, 8);
   endtask

   // with crc on a 16-edge frame does nothing, 32 edges start
   task automatic t_crc;
      wr(ACS_OFF_MODE_REGISTER_0, 32'h1090);
      host.send(ACS_CMD_START, 16);
      wait_res(600);
      chk(32'(result_strobe), 32'h0);
      host.send(ACS_CMD_START, 32);
      wait_res(2000);
      near(BASE, 8);
   endtask

   // chop doubles the first latency, later results one latency apart
   task automatic t_chop;
      wr(ACS_OFF_MODE_REGISTER_0, 32'h1020);
      host.pin(1'b1);
      wait_res(2000);
      near(2 * BASE + 4, 8);
      wait_res(1000);
      near(BASE, 4);
      host.pin(1'b0);
      wait_res(1000);
      near(BASE, 4);
      wait_res(1000);
      chk(32'(result_strobe), 32'h0);
   endtask

   // sticky status, mask and the level interrupt
   task automatic t_irq;
      wr(ACS_OFF_STATUS, 32'h7);
      wr(ACS_OFF_MODE_REGISTER_0, 32'h1010);
      wr(ACS_OFF_MASK, 32'h1);
      host.send(ACS_CMD_START, 16);
      chk(32'(irq), 32'h0);
      wait_res(2000);
      repeat (2) @(posedge mclk);
      #1 chk(32'(irq), 32'h1);
      rd(ACS_OFF_STATUS, 32'h3);
      rd(ACS_OFF_STATE, 32'h4);
      wr(ACS_OFF_MASK, 32'h4);
      rd(ACS_OFF_MASK, 32'h4);
      chk(32'(irq), 32'h0);
      wr(ACS_OFF_STATUS, 32'h7);
      rd(ACS_OFF_STATUS, 32'h0);
   endtask

   // counts and verdict
   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // reset held six cycles, then every scenario in turn
   initial begin
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset();
      t_cont();
      t_single();
      t_restart();
      t_crc();
      t_chop();
      t_irq();
      end_of_test();
   end
endmodule
